// [hw/dac_buf_regs.vh]
// Register offsets, field positions and reset values of the converter buffer control
`ifndef DAC_BUF_REGS_VH
`define DAC_BUF_REGS_VH

// Register indices (byte address is index times four)
`define DAC_IDX_DATA_BASE  8'h00
`define DAC_IDX_STATUS     8'h20
`define DAC_IDX_CTRL0      8'h21
`define DAC_IDX_CTRL1      8'h22
`define DAC_IDX_CTRL2      8'h23

// Buffer geometry
`define DAC_BUF_WORDS      2
`define DAC_PTR_W          1
`define DAC_CODE_W         12

// Control register zero fields
`define C0_CONV_EN         7
`define C0_REF_SEL         6
`define C0_TRIG_SEL        5
`define C0_SW_TRIG         4
`define C0_LOW_POWER       3
`define C0_TOP_IEN         1
`define C0_BOT_IEN         0

// Control register one fields
`define C1_DMA_EN          7
`define C1_MODE_SEL        2
`define C1_BUF_EN          0

// Control register two fields
`define C2_PTR_LSB         4
`define C2_LIM_LSB         0

// Status fields
`define SR_TOP_FLAG        1
`define SR_BOT_FLAG        0

// Reset values
`define C0_RESET           8'h00
`define C1_RESET           8'h00
`define C2_RESET           8'h01

`endif

// [hw/dac_buffer_pointer_control.v]
// Data buffer, read pointer, flags and requests of the 12-bit converter control
`timescale 1ns/10ps
`include "dac_buf_regs.vh"

module dac_buffer_pointer_control
(
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // Register port
    input  wire [9:0]  addr_i,
    input  wire [31:0] wdata_i,
    input  wire        wr_i,
    input  wire        rd_i,
    output reg  [31:0] rdata_o,
    // Trigger and power modes
    input  wire        hw_trigger_i,
    input  wire        stop_mode_i,
    input  wire        low_power_stop_i,
    // DMA handshake
    input  wire        dma_done_i,
    output wire        dma_req_o,
    output wire        irq_o,
    // Converter stage
    output reg  [11:0] conv_code_o,
    output reg         conv_enable_o,
    output reg         ref_select_o,
    output reg         low_power_o
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg  [7:0]  control_reg_zero_q;
    reg  [7:0]  control_reg_one_q;
    reg  [0:0]  buffer_read_pointer_q;
    reg  [0:0]  buffer_upper_limit_q;
    reg         pointer_top_flag_q;
    reg         pointer_bottom_flag_q;
    reg         dma_pending_q;
    reg  [11:0] data_buf_q [0:1];

    wire [7:0]  idx   = addr_i[9:2];
    wire        word_a = (addr_i[1:0] == 2'h0);

    wire conv_en   = control_reg_zero_q[`C0_CONV_EN];
    wire buf_en    = control_reg_one_q[`C1_BUF_EN];
    wire one_shot  = control_reg_one_q[`C1_MODE_SEL];
    wire dma_en    = control_reg_one_q[`C1_DMA_EN];
    // Low-power stop gates the enable, the code and trigger advance off, so no trigger lands while the core sleeps
    wire active    = conv_en & ~low_power_stop_i;

    // Decoding used by several processes
    function hit;
        input [7:0] a;
        input [7:0] want;
        begin
            hit = (a == want);
        end
    endfunction

    // ------------------------------------------------------------
    // Trigger and pointer
    // ------------------------------------------------------------
    wire sw_trig_wr = wr_i & word_a & hit(idx, `DAC_IDX_CTRL0) & wdata_i[`C0_SW_TRIG];
    wire trig = control_reg_zero_q[`C0_TRIG_SEL] ? sw_trig_wr : hw_trigger_i;
    wire advance = active & buf_en & trig;
    wire at_limit = (buffer_read_pointer_q == buffer_upper_limit_q);
    wire c2_wr = wr_i & word_a & hit(idx, `DAC_IDX_CTRL2);
    wire [0:0] wr_ptr = wdata_i[`C2_PTR_LSB +: 1];
    wire [0:0] wr_lim = wdata_i[`C2_LIM_LSB +: 1];

    reg  [0:0]  ptr_d;
    always @*
    begin
        ptr_d = buffer_read_pointer_q;
        if (c2_wr)
        begin
            // Clamp keeps the pointer inside the new limit
            ptr_d = (wr_ptr > wr_lim) ? wr_lim : wr_ptr;
        end
        else if (advance)
        begin
            if (at_limit)
                ptr_d = one_shot ? buffer_read_pointer_q : 1'b0;
            else
                ptr_d = buffer_read_pointer_q + 1'b1;
        end
    end

    wire top_cond = (ptr_d == 1'b0);
    wire bot_cond = (ptr_d == (c2_wr ? wr_lim : buffer_upper_limit_q));

    // ------------------------------------------------------------
    // Sequential state
    // ------------------------------------------------------------
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            control_reg_zero_q    <= `C0_RESET;
            control_reg_one_q     <= `C1_RESET;
            buffer_read_pointer_q <= 1'b0;
            buffer_upper_limit_q  <= 1'b1;
            pointer_top_flag_q    <= 1'b0;
            pointer_bottom_flag_q <= 1'b0;
            dma_pending_q         <= 1'b0;
        end
        else
        begin
            if (wr_i & word_a & hit(idx, `DAC_IDX_CTRL0))
                control_reg_zero_q <= {wdata_i[7:5], 1'b0, wdata_i[3], 1'b0, wdata_i[1:0]};
            // Mode writes touch only this register, pointer is untouched
            if (wr_i & word_a & hit(idx, `DAC_IDX_CTRL1))
                control_reg_one_q <= {wdata_i[7], 4'h0, wdata_i[2], 1'b0, wdata_i[0]};
            buffer_read_pointer_q <= ptr_d;
            if (c2_wr)
                buffer_upper_limit_q <= wr_lim;
            // With DMA the flags hold until done, else a level flag would reappear at once;
            // a new set in the done cycle wins
            if (dma_en)
            begin
                pointer_top_flag_q    <= (pointer_top_flag_q & ~dma_done_i) |
                                         (top_cond & (advance | c2_wr));
                pointer_bottom_flag_q <= (pointer_bottom_flag_q & ~dma_done_i) |
                                         (bot_cond & (advance | c2_wr));
            end
            else
            begin
                pointer_top_flag_q    <= top_cond;
                pointer_bottom_flag_q <= bot_cond;
            end
            if (dma_done_i)
                dma_pending_q <= 1'b0;
            else if (dma_en & (advance | c2_wr) & (top_cond | bot_cond))
                dma_pending_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Data buffer words
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `DAC_BUF_WORDS; g = g + 1)
        begin : g_word
            localparam [7:0] WORD_IDX = g;
            always @(posedge clk_i)
            begin
                if (rst_i)
                    data_buf_q[g] <= 12'h000;
                else if (wr_i & word_a & hit(idx, `DAC_IDX_DATA_BASE + WORD_IDX))
                    data_buf_q[g] <= wdata_i[11:0];
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Converter outputs
    // ------------------------------------------------------------
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            conv_code_o   <= 12'h000;
            conv_enable_o <= 1'b0;
            ref_select_o  <= 1'b0;
            low_power_o   <= 1'b0;
        end
        else
        begin
            conv_enable_o <= active;
            ref_select_o  <= control_reg_zero_q[`C0_REF_SEL];
            low_power_o   <= control_reg_zero_q[`C0_LOW_POWER];
            // Code is frozen through normal stop so the output holds its level
            if (!active)
                conv_code_o <= 12'h000;
            else if (!stop_mode_i)
                conv_code_o <= buf_en ? data_buf_q[buffer_read_pointer_q]
                                      : data_buf_q[0];
        end
    end

    // ------------------------------------------------------------
    // Requests
    // ------------------------------------------------------------
    assign irq_o = ~dma_en & ((pointer_top_flag_q & control_reg_zero_q[`C0_TOP_IEN]) |
                              (pointer_bottom_flag_q & control_reg_zero_q[`C0_BOT_IEN]));
    assign dma_req_o = dma_en & dma_pending_q;

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    reg [31:0] rd_d;
    always @*
    begin
        rd_d = 32'h0000_0000;
        if (word_a)
        begin
            case (idx)
                `DAC_IDX_STATUS: rd_d = {30'h0, pointer_top_flag_q, pointer_bottom_flag_q};
                `DAC_IDX_CTRL0:  rd_d = {24'h0, control_reg_zero_q};
                `DAC_IDX_CTRL1:  rd_d = {24'h0, control_reg_one_q};
                `DAC_IDX_CTRL2:  rd_d = {24'h0, 3'h0, buffer_read_pointer_q,
                                         3'h0, buffer_upper_limit_q};
                8'h00:           rd_d = {20'h0, data_buf_q[0]};
                8'h01:           rd_d = {20'h0, data_buf_q[1]};
                default:         rd_d = 32'h0000_0000;
            endcase
        end
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
            rdata_o <= 32'h0000_0000;
        else if (rd_i)
            rdata_o <= rd_d;
        else
            rdata_o <= 32'h0000_0000;
    end

endmodule // dac_buffer_pointer_control

// [dv/dac_buf_props_properties.sv]
// Port-level assertions for the converter buffer control
`timescale 1ns/10ps
module dac_buf_props
(
    // Clock and reset
    input wire        clk_i,
    input wire        rst_i,
    // Register port
    input wire [9:0]  addr_i,
    input wire [31:0] wdata_i,
    input wire        wr_i,
    input wire        rd_i,
    input wire [31:0] rdata_o,
    // Trigger, power and DMA
    input wire        hw_trigger_i,
    input wire        stop_mode_i,
    input wire        low_power_stop_i,
    input wire        dma_done_i,
    input wire        dma_req_o,
    input wire        irq_o,
    // Converter stage
    input wire [11:0] conv_code_o,
    input wire        conv_enable_o,
    input wire        ref_select_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ctrl2_reserved_a : assert property (
        rd_i && addr_i == 10'h08C |=> rdata_o[7:5] == 3'h0 && rdata_o[3:1] == 3'h0)
        else $error("reserved bits set");
    swtrig_zero_a : assert property (
        rd_i && addr_i == 10'h084 |=> !rdata_o[4]) else $error("trigger bit read 1");
    irq_excl_a : assert property (
        dma_req_o |-> !irq_o) else $error("irq with dma");
    done_clears_a : assert property (
        dma_done_i && !hw_trigger_i && !wr_i |=> !dma_req_o) else $error("req stays");
    shutdown_a : assert property (
        low_power_stop_i |=> !conv_enable_o && conv_code_o == 12'h000)
        else $error("not shut down");
    stop_hold_a : assert property (
        stop_mode_i && !low_power_stop_i |=> $stable(conv_code_o)) else $error("code moved");
    ref_sel_a : assert property (
        wr_i && addr_i == 10'h084 && !low_power_stop_i ##1 !wr_i [*2]
        |-> ref_select_o == $past(wdata_i[6], 2)) else $error("reference wrong");
    conv_en_a : assert property (
        wr_i && addr_i == 10'h084 && !low_power_stop_i ##1 !wr_i [*2]
        |-> conv_enable_o == $past(wdata_i[7], 2)) else $error("enable wrong");
    reset_off_a : assert property (
        $fell(rst_i) |-> !conv_enable_o && !irq_o && !dma_req_o) else $error("reset state");
endmodule // dac_buf_props

bind dac_buffer_pointer_control dac_buf_props u_props (.*);

// [dv/dma_partner.sv]
// DMA engine stand-in answering the converter request with a done pulse
`timescale 1ns/10ps
module dma_partner
(
    // Clock, reset and handshake
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire [7:0] lat_i,
    input  wire       dma_req_i,
    output reg        dma_done_o = 1'b0
);
    reg [7:0] cnt_q = 8'h00;

    // Count restarts after done so done is a one-cycle pulse; a standing request is served again after a new count
    always @(posedge clk_i)
    begin
        if (rst_i || !dma_req_i || dma_done_o)
        begin
            cnt_q      <= 8'h00;
            dma_done_o <= 1'b0;
        end
        else if (cnt_q >= lat_i)
            dma_done_o <= 1'b1;
        else
            cnt_q <= cnt_q + 8'h01;
    end
endmodule // dma_partner

// [dv/test_dac_buffer_pointer_control.sv]
// Register-level test sequence for the converter buffer control
`timescale 1ns/10ps
module test_dac_buffer_pointer_control;
    reg         clk_i = 1'b0;
    reg         rst_i = 1'b1;
    reg  [9:0]  addr_i = 10'h000;
    reg  [31:0] wdata_i = 32'h0;
    reg         wr_i = 1'b0;
    reg         rd_i = 1'b0;
    reg         hw_trigger_i = 1'b0;
    reg         stop_mode_i = 1'b0;
    reg         low_power_stop_i = 1'b0;
    reg  [7:0]  lat = 8'h01;
    wire        lp_o;
    wire [31:0] rdata_o;
    wire [11:0] conv_code_o;
    wire        dma_done_i, dma_req_o, irq_o, conv_enable_o, ref_select_o;
    integer     error_cnt = 0;
    integer     checked = 0;
    integer     n;

    always #5 clk_i = ~clk_i;
    dac_buffer_pointer_control u_dut (.*, .low_power_o(lp_o));
    dma_partner u_dma (.clk_i(clk_i), .rst_i(rst_i), .lat_i(lat), .dma_req_i(dma_req_o),
        .dma_done_o(dma_done_i));

    // ----
    // Bus and compare tasks
    // ----
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp)
            begin
                error_cnt = error_cnt + 1;
                $display("BAD %0t got %h want %h", $time, seen, exp);
            end
        end
    endtask
    task wr(input [7:0] idx, input [11:0] d);
        begin
            @(posedge clk_i);
            wr_i <= 1'b1;
            addr_i <= {idx, 2'b00};
            wdata_i <= {20'h0, d};
            @(posedge clk_i);
            wr_i <= 1'b0;
        end
    endtask
    task rchk(input [7:0] idx, input [31:0] exp);
        begin
            @(posedge clk_i);
            rd_i <= 1'b1;
            addr_i <= {idx, 2'b00};
            @(posedge clk_i);
            rd_i <= 1'b0;
            #1 chk(rdata_o, exp);
        end
    endtask
    task idle;
        begin
            repeat (2) @(posedge clk_i);
            #1;
        end
    endtask
    task trig;
        begin
            @(posedge clk_i);
            hw_trigger_i <= 1'b1;
            @(posedge clk_i);
            hw_trigger_i <= 1'b0;
            idle;
        end
    endtask
    // Bounded poll; a missing answer shows up as a mismatch, not a hang
    task wait_req(input lvl);
        begin
            #1 n = 0;
            while (dma_req_o !== lvl && n < 30)
            begin
                @(posedge clk_i);
                #1 n = n + 1;
            end
            chk({31'h0, dma_req_o}, {31'h0, lvl});
        end
    endtask
    task summarize;
        begin
            $display("checks %0d errors %0d", checked, error_cnt);
            if (error_cnt == 0 && checked > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask

    initial
    begin
        #100000 error_cnt = error_cnt + 1;
        summarize;
    end

    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rchk(8'h21, 32'h0);
        rchk(8'h22, 32'h0);
        rchk(8'h23, 32'h1);
        rchk(8'h30, 32'h0);
        chk({31'h0, lp_o}, 32'h0);
        wr(8'h00, 12'hA5C);
        wr(8'h01, 12'h3F1);
        wr(8'h21, 12'h0C0);
        idle;
        chk({31'h0, ref_select_o}, 32'h1);
        wr(8'h21, 12'h080);
        trig;
        chk({20'h0, conv_code_o}, 32'hA5C);
        wr(8'h22, 12'h001);
        trig;
        rchk(8'h23, 32'h11);
        chk({20'h0, conv_code_o}, 32'h3F1);
        rchk(8'h20, 32'h1);
        trig;
        rchk(8'h23, 32'h1);
        rchk(8'h20, 32'h2);
        wr(8'h22, 12'h005);
        rchk(8'h23, 32'h1);
        trig;
        trig;
        rchk(8'h23, 32'h11);
        wr(8'h23, 12'h001);
        trig;
        rchk(8'h23, 32'h11);
        wr(8'h23, 12'h011);
        trig;
        rchk(8'h23, 32'h11);
        wr(8'h22, 12'h001);
        wr(8'h21, 12'h0A0);
        trig;
        rchk(8'h23, 32'h11);
        wr(8'h21, 12'h0B0);
        rchk(8'h23, 32'h1);
        rchk(8'h21, 32'hA0);
        wr(8'h21, 12'h0A2);
        idle;
        chk({31'h0, irq_o}, 32'h1);
        wr(8'h21, 12'h0A1);
        idle;
        chk({31'h0, irq_o}, 32'h0);
        wr(8'h22, 12'h081);
        wr(8'h21, 12'h0B1);
        wait_req(1'b1);
        chk({31'h0, irq_o}, 32'h0);
        wait_req(1'b0);
        rchk(8'h20, 32'h0);
        lat <= 8'h0C;
        wr(8'h21, 12'h0B1);
        wait_req(1'b1);
        rchk(8'h20, 32'h2);
        wait_req(1'b0);
        rchk(8'h20, 32'h0);
        wr(8'h22, 12'h001);
        @(posedge clk_i);
        stop_mode_i <= 1'b1;
        wr(8'h21, 12'h0B0);
        idle;
        chk({20'h0, conv_code_o}, 32'hA5C);
        chk({31'h0, conv_enable_o}, 32'h1);
        @(posedge clk_i);
        low_power_stop_i <= 1'b1;
        idle;
        chk({31'h0, conv_enable_o}, 32'h0);
        summarize;
    end
endmodule // test_dac_buffer_pointer_control
